/* rtl/iaa_cfg.svh */
// Constants of the interrupt agent: register offsets, reset values, limits.
// Assumes inclusion by iaa_pkg.sv and the design modules only.
`ifndef IAA_CFG_SVH
`define IAA_CFG_SVH
// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define IAA_ADDR_W 8
`define IAA_OFS_ID 8'h00
`define IAA_OFS_TPL 8'h04
`define IAA_OFS_PPL 8'h08
`define IAA_OFS_EOS 8'h0C
`define IAA_OFS_STAT 8'h10
// ****************************************************************
// Reset values and field positions
// ****************************************************************
`define IAA_ID_RST 4'h0
`define IAA_TPL_RST 8'h00
`define IAA_WIN_ZERO 4'h0
`define IAA_WIN_STEP 4'h1
`define IAA_CLS_HI 7
`define IAA_CLS_LO 4
`define IAA_SUB_ZERO 4'h0
`define IAA_VEC_ZERO 8'h00
`define IAA_CLS_SLOTS 6'h02
`define IAA_CLS_SIZE 16
`endif

/* rtl/iaa_pkg.sv */
// Types shared by the interrupt agent modules.
// Assumes iaa_cfg.svh sits beside it on the include path.
`include "iaa_cfg.svh"
package iaa_pkg;
  // ****************************************************************
  // Delivery modes and message carriers
  // ****************************************************************
  typedef enum logic [3:0] {
    DM_FIXED, DM_LOWEST, DM_NMI, DM_SMI, DM_SOFTRST, DM_RESTART_REL,
    DM_STARTUP, DM_EXTCTL, DM_BOOTSEL, DM_FINALSEL
  } iaa_mode_t;
  typedef struct packed {
    logic valid;
    iaa_mode_t mode;
    logic [7:0] vector;
    logic level;
    logic addressed;
  } iaa_msg_t;
  typedef enum logic [1:0] {OK_NONE, OK_COMPLETE, OK_CORE} iaa_okind_t;
  typedef struct packed {
    logic valid;
    iaa_okind_t kind;
    iaa_mode_t mode;
    logic [7:0] vector;
  } iaa_out_t;
  typedef enum logic [1:0] {SL_IDLE, SL_ARB, SL_SEND} iaa_slot_t;
endpackage : iaa_pkg

/* rtl/iaa_hi_find.sv */
// Finds the highest set bit of a vector and returns its index.
// Assumes a purely combinational use inside the interrupt agent.
`timescale 1ns/1ps
module iaa_hi_find #(
  parameter int W = 256,
  parameter int IW = 8
) (
  // Vector in
  input wire logic [W-1:0] vec,
  // Result
  output logic found,
  output logic [IW-1:0] idx
);
  initial begin
    if (W > (1 << IW)) begin
      $error("iaa_hi_find: index too narrow");
    end
  end
  always_comb begin
    found = 1'b0;
    idx = '0;
    for (int i = 0; i < W; i++) begin
      if (vec[i]) begin
        found = 1'b1;
        idx = IW'(i);
      end
    end
  end
endmodule : iaa_hi_find

/* rtl/iaa_agent.sv */
// Per-processor interrupt agent: bus arbitration priority, acceptance,
// pending and in-service queues, dispatch to the core, end of service.
// Assumes destination decoding is done outside and flagged in each message.
// Summary of operation
// [R01] Legacy variant holds a bus-win priority from zero to fifteen.
// [R02] Highest bus-win priority wins the message bus.
// [R03] Winner drops its priority to zero, each loser adds one.
// [R04] Priority is a hidden 4-bit register, absent in system-bus variant.
// [R05] Reset loads the priority from the agent identifier.
// [R06] Restart-release message reloads priority from the agent identifier.
// [R07] Undelivered bus messages are retried, except startup messages.
// [R08] Software must not message disabled or absent agents.
// [R09] Accept addressed messages, discard all others.
// [R10] Special delivery modes bypass the queues and go to the core.
// [R11] System-bus variant sets the pending bit of the vector.
// [R12] Legacy variant queues a fixed interrupt in a free slot.
// [R13] Legacy variant with no free slot rejects and answers retry.
// [R14] Dispatch one at a time by vector, task and processor priority.
// [R15] End-of-service write removes the current in-service interrupt.
// [R16] Retiring a level-triggered interrupt sends a completion message; a completion still waiting is lost if a second one retires.
// [R17] Handlers of special modes must not write end of service.
// [R18] Legacy lowest-priority delivery is kept only by the winner.
// [R19] System-bus variant ordering follows the system bus arbitration.
// [R20] Core ready moves highest pending bit into in-service.
// [R21] Priority class is the upper four vector bits.
// [R22] Dispatch only classes above the task priority level.
// [R23] Legacy queues hold at most two interrupts per class.
// [R24] Reset clears pending and in-service vectors.
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "iaa_cfg.svh"
module iaa_agent
  import iaa_pkg::*;
#(
  parameter bit LEGACY = 1'b1,
  parameter int NVEC = 256
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Register port
  input wire logic [`IAA_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // Incoming messages
  input wire iaa_msg_t msgIn,
  input wire logic lowWon,
  output logic msgRetry,
  // Outgoing messages and bus arbitration
  input wire iaa_out_t coreSend,
  output logic coreSendReady,
  output logic busReq,
  input wire logic arbRound,
  input wire logic arbWon,
  input wire logic busDone,
  input wire logic busFail,
  output iaa_out_t msgOut,
  output logic [3:0] busWinPriority,
  // Core side
  output iaa_msg_t coreBypass,
  input wire logic coreReady,
  output logic coreIntValid,
  output logic [7:0] coreIntVector
);
  initial begin
    if (NVEC != 256) begin
      $error("iaa_agent: vector space must be 256");
    end
  end
  // ****************************************************************
  // State
  // ****************************************************************
  logic [3:0] agentIdentifier_ff;
  logic [7:0] taskPriorityLevel_ff;
  logic [3:0] busWin_ff;
  logic [NVEC-1:0] pending_ff, inService_ff, trigLevel_ff;
  logic [NVEC-1:0] nxt_pending, nxt_inService, nxt_trigLevel;
  logic [31:0] regRdata_ff;
  logic msgRetry_ff;
  iaa_msg_t coreBypass_ff;
  logic coreIntValid_ff;
  logic [7:0] coreIntVector_ff;
  logic compPend_ff;
  logic [7:0] compVec_ff;
  iaa_slot_t slot_ff;
  iaa_out_t slotMsg_ff;
  // ****************************************************************
  // Decoding
  // ****************************************************************
  wire logic wrId = regWr && (regAddr == `IAA_OFS_ID);
  wire logic wrTpl = regWr && (regAddr == `IAA_OFS_TPL);
  wire logic wrEos = regWr && (regAddr == `IAA_OFS_EOS);
  wire logic pendFound, servFound;
  wire logic [7:0] pendIdx, servIdx;
  iaa_hi_find #(.W(NVEC), .IW(8)) uPend (
    .vec(pending_ff),
    .found(pendFound),
    .idx(pendIdx)
  );
  iaa_hi_find #(.W(NVEC), .IW(8)) uServ (
    .vec(inService_ff),
    .found(servFound),
    .idx(servIdx)
  );
  // Class is the upper vector nibble; empty vectors count as class zero
  wire logic [3:0] pendCls = pendFound ? pendIdx[`IAA_CLS_HI:`IAA_CLS_LO] : 4'h0; // [R21]
  wire logic [3:0] servCls = servFound ? servIdx[`IAA_CLS_HI:`IAA_CLS_LO] : 4'h0; // [R21]
  wire logic [3:0] tplCls = taskPriorityLevel_ff[`IAA_CLS_HI:`IAA_CLS_LO];
  wire logic tplWins = tplCls >= servCls;
  wire logic [7:0] procPriorityLevel = tplWins ? taskPriorityLevel_ff
                                              : {servCls, `IAA_SUB_ZERO}; // [R14]
  // Processor level is never below task level, so one compare serves both
  wire logic canDispatch = pendFound
                         && (pendCls > procPriorityLevel[`IAA_CLS_HI:`IAA_CLS_LO]); // [R22]
  wire logic doDispatch = coreReady && canDispatch; // [R14] [R20]
  wire logic doRetire = wrEos && servFound; // [R15]
  wire logic retireLevel = doRetire && trigLevel_ff[servIdx]; // [R16]
  // ****************************************************************
  // Acceptance
  // ****************************************************************
  wire logic isFixed = (msgIn.mode == DM_FIXED) || (msgIn.mode == DM_LOWEST);
  wire logic legacyOnly = (msgIn.mode == DM_RESTART_REL) || (msgIn.mode == DM_BOOTSEL)
                        || (msgIn.mode == DM_FINALSEL);
  wire logic hit = msgIn.valid && msgIn.addressed; // [R09]
  // In the legacy variant, lowest-priority delivery is kept only by the agent that won for it
  wire logic lowKeep = !(LEGACY && (msgIn.mode == DM_LOWEST)) || lowWon; // [R18]
  wire logic takeBypass = hit && !isFixed && (LEGACY || !legacyOnly); // [R10]
  wire logic takeRestart = hit && LEGACY && (msgIn.mode == DM_RESTART_REL); // [R06]
  wire logic [3:0] inCls = msgIn.vector[`IAA_CLS_HI:`IAA_CLS_LO];
  logic [5:0] clsCount;
  always_comb begin
    clsCount = 6'h00;
    for (int i = 0; i < `IAA_CLS_SIZE; i++) begin
      clsCount = clsCount + 6'(pending_ff[{inCls, 4'(i)}])
                          + 6'(inService_ff[{inCls, 4'(i)}]);
    end
  end
  // A legacy slot needs a class below two entries and a clear pending bit
  wire logic slotFree = (clsCount < `IAA_CLS_SLOTS) && !pending_ff[msgIn.vector]; // [R23]
  wire logic fixedHit = hit && isFixed && lowKeep;
  wire logic takeFixed = fixedHit && (!LEGACY || slotFree); // [R11] [R12]
  wire logic rejectFixed = fixedHit && LEGACY && !slotFree; // [R13]
  // ****************************************************************
  // Queue update
  // ****************************************************************
  always_comb begin
    nxt_pending = pending_ff;
    nxt_inService = inService_ff;
    nxt_trigLevel = trigLevel_ff;
    if (doRetire) begin
      nxt_inService[servIdx] = 1'b0; // [R15]
    end
    if (doDispatch) begin
      nxt_pending[pendIdx] = 1'b0; // [R20]
      nxt_inService[pendIdx] = 1'b1; // [R20]
    end
    // Setting after clearing lets an arrival survive a same-cycle dispatch
    if (takeFixed) begin
      nxt_pending[msgIn.vector] = 1'b1; // [R11] [R12]
      nxt_trigLevel[msgIn.vector] = msgIn.level;
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pending_ff <= '0; // [R24]
      inService_ff <= '0; // [R24]
      trigLevel_ff <= '0;
    end else begin
      pending_ff <= nxt_pending;
      inService_ff <= nxt_inService;
      trigLevel_ff <= nxt_trigLevel;
    end
  end
  // ****************************************************************
  // Core side
  // ****************************************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      coreBypass_ff <= '0;
      coreIntValid_ff <= 1'b0;
      coreIntVector_ff <= `IAA_VEC_ZERO;
      msgRetry_ff <= 1'b0;
    end else begin
      coreBypass_ff <= takeBypass ? msgIn : '0; // [R10]
      coreIntValid_ff <= doDispatch; // [R14]
      coreIntVector_ff <= doDispatch ? pendIdx : coreIntVector_ff;
      msgRetry_ff <= rejectFixed; // [R13]
    end
  end
  // ****************************************************************
  // Bus-win priority
  // ****************************************************************
  // Identifier and priority share one reset constant, so reset loads one from the other
  logic [3:0] nxt_busWin;
  always_comb begin
    nxt_busWin = busWin_ff;
    if (takeRestart) begin
      nxt_busWin = agentIdentifier_ff; // [R06]
    end else if (arbRound && arbWon) begin
      nxt_busWin = `IAA_WIN_ZERO; // [R03]
    end else if (arbRound) begin
      nxt_busWin = busWin_ff + `IAA_WIN_STEP; // [R03]
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      busWin_ff <= `IAA_ID_RST; // [R05]
    end else begin
      busWin_ff <= nxt_busWin; // [R01]
    end
  end
  // Absent in the system-bus variant; the router grants the highest value
  assign busWinPriority = LEGACY ? busWin_ff : `IAA_WIN_ZERO; // [R02] [R04]
  // ****************************************************************
  // Outbound message slot
  // ****************************************************************
  wire logic slotFreeOut = (slot_ff == SL_IDLE);
  wire logic loadComp = slotFreeOut && compPend_ff;
  wire logic loadCore = slotFreeOut && !compPend_ff && coreSend.valid;
  assign coreSendReady = slotFreeOut && !compPend_ff;
  // Startup messages are dropped on failure; all others go back to arbitration
  wire logic failRetry = busFail && (slotMsg_ff.mode != DM_STARTUP); // [R07]
  iaa_slot_t nxt_slot;
  always_comb begin
    nxt_slot = slot_ff;
    unique case (slot_ff)
      SL_IDLE: begin
        if (loadComp || loadCore) begin
          nxt_slot = SL_ARB;
        end
      end
      SL_ARB: begin
        // Ordering is whatever the bus arbitration grants
        if (arbRound && arbWon) begin
          nxt_slot = SL_SEND; // [R19]
        end
      end
      SL_SEND: begin
        if (failRetry) begin
          nxt_slot = SL_ARB; // [R07]
        end else if (busDone || busFail) begin
          nxt_slot = SL_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      slot_ff <= SL_IDLE;
      slotMsg_ff <= '0;
    end else begin
      slot_ff <= nxt_slot;
      if (loadComp) begin
        slotMsg_ff <= '{valid: 1'b1, kind: OK_COMPLETE, mode: DM_FIXED,
                        vector: compVec_ff}; // [R16]
      end else if (loadCore) begin
        slotMsg_ff <= coreSend;
      end
    end
  end
  // One completion waits here; a second while it waits overwrites its vector, so the first is lost
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      compPend_ff <= 1'b0;
      compVec_ff <= `IAA_VEC_ZERO;
    end else if (retireLevel) begin
      compPend_ff <= 1'b1; // [R16]
      compVec_ff <= servIdx;
    end else if (loadComp) begin
      compPend_ff <= 1'b0;
    end
  end
  assign busReq = (slot_ff == SL_ARB);
  assign msgOut = (slot_ff == SL_SEND) ? slotMsg_ff : '0;
  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      agentIdentifier_ff <= `IAA_ID_RST;
      taskPriorityLevel_ff <= `IAA_TPL_RST;
    end else begin
      if (wrId) begin
        agentIdentifier_ff <= regWdata[3:0];
      end
      if (wrTpl) begin
        taskPriorityLevel_ff <= regWdata[7:0];
      end
    end
  end
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (regAddr)
      `IAA_OFS_ID: rdMux = {28'h000_0000, agentIdentifier_ff};
      `IAA_OFS_TPL: rdMux = {24'h00_0000, taskPriorityLevel_ff};
      `IAA_OFS_PPL: rdMux = {24'h00_0000, procPriorityLevel};
      `IAA_OFS_STAT: rdMux = {14'h0000, pendFound, servFound, pendIdx, servIdx};
      default: rdMux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      regRdata_ff <= 32'h0000_0000;
    end else begin
      regRdata_ff <= regRd ? rdMux : 32'h0000_0000;
    end
  end
  assign regRdata = regRdata_ff;
  assign msgRetry = msgRetry_ff;
  assign coreBypass = coreBypass_ff;
  assign coreIntValid = coreIntValid_ff;
  assign coreIntVector = coreIntVector_ff;
endmodule : iaa_agent

/* bench/iaa_agent_chk.sv */
// Port assertions for the interrupt agent, legacy variant.
// Assumes it is bound to iaa_agent with LEGACY set.
`timescale 1ns/1ps
module iaa_agent_chk
  import iaa_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Watched ports
  input wire iaa_msg_t msgIn,
  input wire logic msgRetry,
  input wire logic busReq,
  input wire logic arbRound,
  input wire logic arbWon,
  input wire logic busFail,
  input wire iaa_out_t msgOut,
  input wire logic [3:0] busWinPriority,
  input wire iaa_msg_t coreBypass,
  input wire logic coreReady,
  input wire logic coreIntValid
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic reload;
  assign reload = msgIn.valid && msgIn.addressed && msgIn.mode == DM_RESTART_REL;
  property p_win;
    arbRound && arbWon && !reload |=> busWinPriority == 4'h0;
  endproperty
  a_win: assert property (p_win) else $error("winner priority not zero");
  property p_lose;
    arbRound && !arbWon && !reload |=> busWinPriority == $past(busWinPriority) + 4'h1;
  endproperty
  a_lose: assert property (p_lose) else $error("loser priority not raised");
  property p_keep;
    !arbRound && !reload |=> $stable(busWinPriority);
  endproperty
  a_keep: assert property (p_keep) else $error("priority moved unprompted");
  property p_grant;
    busReq && arbRound && arbWon |=> msgOut.valid && !busReq;
  endproperty
  a_grant: assert property (p_grant) else $error("won round not used");
  property p_retry;
    msgOut.valid && busFail && msgOut.mode != DM_STARTUP |-> ##[1:2] busReq;
  endproperty
  a_retry: assert property (p_retry) else $error("failed message not retried");
  property p_drop;
    msgOut.valid && busFail && msgOut.mode == DM_STARTUP |=> !busReq && !msgOut.valid;
  endproperty
  a_drop: assert property (p_drop) else $error("startup message retried");
  property p_discard;
    msgIn.valid && !msgIn.addressed |=> !coreBypass.valid && !msgRetry;
  endproperty
  a_discard: assert property (p_discard) else $error("foreign message acted on");
  property p_nmi;
    msgIn.valid && msgIn.addressed && msgIn.mode == DM_NMI
      |=> coreBypass.valid && coreBypass.mode == DM_NMI;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nonmaskable not bypassed");
  property p_disp;
    coreIntValid |-> $past(coreReady);
  endproperty
  a_disp: assert property (p_disp) else $error("dispatch without core ready");
  c_lose: cover property (arbRound && !arbWon);
  c_fail: cover property (busFail);
  c_byp: cover property (coreBypass.valid);
endmodule : iaa_agent_chk

bind iaa_agent iaa_agent_chk iaa_agent_chk_inst (.core_clk, .resetn, .msgIn, .msgRetry,
  .busReq, .arbRound, .arbWon, .busFail, .msgOut, .busWinPriority, .coreBypass,
  .coreReady, .coreIntValid);

/* bench/iaa_bus_model.sv */
// Message bus model: router arbitration rounds and delivery replies.
// Assumes one agent on the bus; the bench steers losses and failures.
`timescale 1ns/1ps
module iaa_bus_model
  import iaa_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Agent side
  input wire logic busReq,
  input wire iaa_out_t msgOut,
  output logic arbRound,
  output logic arbWon,
  output logic busDone,
  output logic busFail,
  // Bench control
  input wire logic [3:0] nLose,
  input wire logic failOne,
  output logic [7:0] tries,
  output iaa_okind_t lastKind
);
  // ****************************************************************
  // Arbitration and delivery
  // ****************************************************************
  logic [3:0] lost;
  logic used;
  logic resp;
  assign resp = msgOut.valid && !busDone && !busFail;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      {arbRound, arbWon, busDone, busFail, used, lost, tries} <= '0;
      lastKind <= OK_NONE;
    end else begin
      arbRound <= busReq && !arbRound;
      arbWon <= busReq && !arbRound && lost >= nLose;
      if (busReq && !arbRound) begin
        lost <= (lost >= nLose) ? 4'h0 : lost + 4'h1;
      end
      // Fails only one attempt, so a retried message cannot loop forever
      busFail <= resp && failOne && !used;
      busDone <= resp && !(failOne && !used);
      if (resp && failOne) begin
        used <= 1'b1;
      end else if (!failOne || busDone) begin
        used <= 1'b0;
      end
      if (resp) begin
        tries <= tries + 8'h01;
        lastKind <= msgOut.kind;
      end
    end
  end
endmodule : iaa_bus_model

/* bench/iaa_agent_tb.sv */
// Self-checking bench for the interrupt agent, legacy variant.
// Assumes iaa_bus_model answers the message bus side.
`timescale 1ns/1ps
module iaa_agent_tb
  import iaa_pkg::*;
;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0, regRdata, rdv;
  logic regWr = 1'b0, regRd = 1'b0, lowWon = 1'b0, coreReady = 1'b0, failOne = 1'b0;
  iaa_msg_t msgIn = '0, coreBypass, byp;
  iaa_out_t coreSend = '0, msgOut;
  logic coreSendReady, busReq, arbRound, arbWon, busDone, busFail, msgRetry, rty;
  logic coreIntValid;
  logic [7:0] coreIntVector, lastVec, tries, t0;
  logic [3:0] busWinPriority, nLose = 4'h0;
  iaa_okind_t lastKind;
  int errors = 0, nChecks = 0, nDisp = 0, n0;
  iaa_mode_t md[7] = '{DM_NMI, DM_SMI, DM_SOFTRST, DM_EXTCTL, DM_STARTUP, DM_BOOTSEL,
    DM_FINALSEL};
  always #25 core_clk = ~core_clk;
  iaa_agent #(.LEGACY(1'b1)) iaa_agent_inst (.core_clk, .resetn, .regAddr, .regWdata,
    .regWr, .regRd, .regRdata, .msgIn, .lowWon, .msgRetry, .coreSend, .coreSendReady,
    .busReq, .arbRound, .arbWon, .busDone, .busFail, .msgOut, .busWinPriority,
    .coreBypass, .coreReady, .coreIntValid, .coreIntVector);
  iaa_bus_model iaa_bus_model_inst (.core_clk, .resetn, .busReq, .msgOut, .arbRound,
    .arbWon, .busDone, .busFail, .nLose, .failOne, .tries, .lastKind);
  always @(posedge core_clk) begin
    if (coreIntValid === 1'b1) begin
      lastVec <= coreIntVector;
      nDisp <= nDisp + 1;
    end
  end
  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  task chk(input logic ok, input string m);
    nChecks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regWr <= 1'b1; regAddr <= a; regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge core_clk);
    regRd <= 1'b1; regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(negedge core_clk);
    rdv = regRdata;
  endtask : rd
  task msg(input iaa_mode_t m, input logic [7:0] v, input logic lv, ad, lw);
    @(posedge core_clk);
    msgIn <= '{1'b1, m, v, lv, ad}; lowWon <= lw;
    @(posedge core_clk);
    msgIn <= '0; lowWon <= 1'b0;
    @(negedge core_clk);
    byp = coreBypass; rty = msgRetry;
  endtask : msg
  task wait_idle();
    for (int i = 0; i < 8; i++) begin
      @(negedge core_clk);
      if (busReq) break;
    end
    for (int i = 0; i < 60; i++) begin
      @(negedge core_clk);
      if (!busReq && !msgOut.valid && coreSendReady) break;
    end
  endtask : wait_idle
  task send(input iaa_mode_t m);
    t0 = tries;
    @(posedge core_clk);
    coreSend <= '{1'b1, OK_CORE, m, 8'h00};
    @(posedge core_clk);
    coreSend <= '0;
    wait_idle();
  endtask : send
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_reset();
    chk(busWinPriority === 4'h0, "priority after reset");
    rd(8'h10); chk(rdv === 32'h0, "queues after reset");
    rd(8'h40); chk(rdv === 32'h0, "unmapped read");
  endtask : t_reset
  task t_prio();
    wr(8'h00, 32'h5);
    msg(DM_RESTART_REL, 8'h00, 1'b0, 1'b0, 1'b0);
    chk(busWinPriority === 4'h0 && byp.valid === 1'b0, "foreign restart");
    msg(DM_RESTART_REL, 8'h00, 1'b0, 1'b1, 1'b0);
    chk(busWinPriority === 4'h5 && byp.valid === 1'b1, "restart reload");
    nLose = 4'h2;
    send(DM_FIXED);
    chk(busWinPriority === 4'h0 && tries - t0 === 8'h01, "win after losses");
    nLose = 4'h0;
  endtask : t_prio
  task t_bypass();
    // Special modes are never followed by an end-of-service write
    for (int i = 0; i < 7; i++) begin
      msg(md[i], 8'h20, 1'b0, 1'b1, 1'b0);
      chk(byp.valid === 1'b1 && byp.mode === md[i], "bypass mode");
    end
    rd(8'h10); chk(rdv[17] === 1'b0, "bypass queued");
    msg(DM_NMI, 8'h20, 1'b0, 1'b0, 1'b0);
    chk(byp.valid === 1'b0, "unaddressed bypass");
  endtask : t_bypass
  task t_retry();
    failOne = 1'b1;
    send(DM_FIXED); chk(tries - t0 === 8'h02, "fixed retry");
    send(DM_STARTUP); chk(tries - t0 === 8'h01, "startup retried");
    failOne = 1'b0;
  endtask : t_retry
  task t_queue();
    wr(8'h04, 32'h50);
    rd(8'h04); chk(rdv[7:0] === 8'h50, "task level readback");
    msg(DM_FIXED, 8'h45, 1'b0, 1'b1, 1'b0);
    rd(8'h10); chk(rdv[17] === 1'b1 && rdv[15:8] === 8'h45, "pending bit");
    rd(8'h08); chk(rdv[7:0] === 8'h50, "processor level");
    @(posedge core_clk);
    coreReady <= 1'b1;
    n0 = nDisp;
    repeat (4) @(posedge core_clk);
    chk(nDisp == n0, "class below task level sent");
    msg(DM_FIXED, 8'h65, 1'b0, 1'b1, 1'b0);
    repeat (3) @(posedge core_clk);
    chk(lastVec === 8'h65 && nDisp == n0 + 1, "dispatch");
    wr(8'h04, 32'h0);
    repeat (3) @(posedge core_clk);
    chk(nDisp == n0 + 1, "lower class preempted");
    wr(8'h0C, 32'h0);
    repeat (3) @(posedge core_clk);
    chk(lastVec === 8'h45, "next after retire");
    wr(8'h0C, 32'h0);
    rd(8'h10); chk(rdv[17:16] === 2'b00, "queues empty");
  endtask : t_queue
  task t_level();
    msg(DM_FIXED, 8'h80, 1'b1, 1'b1, 1'b0);
    repeat (3) @(posedge core_clk);
    chk(lastVec === 8'h80, "level dispatch");
    t0 = tries;
    wr(8'h0C, 32'h0);
    wait_idle();
    chk(tries - t0 === 8'h01 && lastKind === OK_COMPLETE, "completion");
    @(posedge core_clk);
    coreReady <= 1'b0;
  endtask : t_level
  task t_accept();
    msg(DM_LOWEST, 8'h70, 1'b0, 1'b1, 1'b0);
    rd(8'h10); chk(rdv[17] === 1'b0, "lowest kept by loser");
    msg(DM_LOWEST, 8'h70, 1'b0, 1'b1, 1'b1);
    rd(8'h10); chk(rdv[15:8] === 8'h70, "lowest winner");
    msg(DM_FIXED, 8'h30, 1'b0, 1'b1, 1'b0);
    msg(DM_FIXED, 8'h31, 1'b0, 1'b1, 1'b0);
    chk(rty === 1'b0, "second slot");
    msg(DM_FIXED, 8'h32, 1'b0, 1'b1, 1'b0);
    chk(rty === 1'b1, "full class");
    msg(DM_FIXED, 8'h48, 1'b0, 1'b1, 1'b0);
    chk(rty === 1'b0, "other class");
  endtask : t_accept
  task end_sim();
    $display("checks %0d errors %0d", nChecks, errors);
    if (errors == 0 && nChecks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  initial begin
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    t_reset(); t_prio(); t_bypass(); t_retry(); t_queue(); t_level(); t_accept();
    end_sim();
  end
  // Whole run needs well under 1000 cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    errors++;
    $display("mismatch at %0t: watchdog", $time);
    end_sim();
  end
endmodule : iaa_agent_tb
